// ---- design/mcmr_pkg.sv ----
package mcmr_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] MCMR_ADDR_CONV_SETUP = 8'h1a;
  localparam logic [7:0] MCMR_ADDR_MASK_FIRST = 8'h1d;
  localparam logic [7:0] MCMR_ADDR_MASK_SECOND = 8'h1e;
  localparam logic [7:0] MCMR_ADDR_TEMP_OFFSET = 8'h1f;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MCMR_RST_CONV_SETUP = 8'h08;
  localparam logic [7:0] MCMR_RST_MASK_FIRST = 8'h00;
  localparam logic [7:0] MCMR_RST_MASK_SECOND = 8'h00;
  localparam logic [7:0] MCMR_RST_TEMP_OFFSET = 8'h00;

  // ---------------------------------------------------------------
  // Field positions and second mask used width
  // ---------------------------------------------------------------
  localparam int MCMR_FAST_CONV_SEL_BIT = 0;
  localparam int MCMR_REFERENCE_SEL_BIT = 4;
  localparam int MCMR_MASK_SECOND_USED = 5;

  // ---------------------------------------------------------------
  // Timing: converter clock rates and divider counts at 100 MHz
  // ---------------------------------------------------------------
  localparam int MCMR_CLK_HZ = 100_000_000;
  localparam int MCMR_SLOW_CONV_HZ = 1_400;
  localparam int MCMR_FAST_CONV_HZ = 22_500;
  localparam int MCMR_SLOW_DIV = MCMR_CLK_HZ / MCMR_SLOW_CONV_HZ;
  localparam int MCMR_FAST_DIV = MCMR_CLK_HZ / MCMR_FAST_CONV_HZ;
  localparam int MCMR_DIV_W = 17;

  // Interrupt sources, one bit each
  typedef struct packed {
    logic supply;
    logic [3:0] ain_five_to_eight;
    logic [2:0] ain_two_to_four;
    logic ext_fault;
    logic ext_low;
    logic ext_high_or_ain_one;
    logic int_low;
    logic int_high;
  } mcmr_irq_src_s;

  // Host register write/read request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcmr_reg_req_s;

endpackage

// ---- design/mcmr_regs.sv ----
`timescale 1ns/1ps
module mcmr_regs
#(
  parameter int TEMP_W = 10,
  parameter int FRAC_W = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Host register access
  input wire mcmr_pkg::mcmr_reg_req_s i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Interrupt sources and pin control
  input wire mcmr_pkg::mcmr_irq_src_s i_irq_src,
  input wire logic i_int_pin_disable,
  input wire logic i_int_pin_active_high,
  output logic o_int_pin,
  // Converter control
  output logic o_fast_conv_sel,
  output logic o_reference_sel,
  output logic o_diode_filter_bypass,
  output logic o_conv_clk_tick,
  // Internal temperature path
  input wire logic i_temp_valid,
  input wire logic [TEMP_W-1:0] i_temp_raw,
  output logic o_temp_valid,
  output logic [TEMP_W-1:0] o_temp_result
);
  import mcmr_pkg::*;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  // Each register decodes its own address, so an unmapped write lands nowhere
  logic [7:0] conv_setup_q;
  logic [7:0] mask_first_q;
  logic [7:0] mask_second_q;
  logic [7:0] temp_offset_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // Reserved bits are stored as written; host keeps them legal
  mcmr_reg8 #(
    .ADDR(MCMR_ADDR_CONV_SETUP),
    .RST(MCMR_RST_CONV_SETUP)
  ) conv_setup_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(i_req),
    .o_value(conv_setup_q)
  );

  mcmr_reg8 #(
    .ADDR(MCMR_ADDR_MASK_FIRST),
    .RST(MCMR_RST_MASK_FIRST)
  ) mask_first_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(i_req),
    .o_value(mask_first_q)
  );

  mcmr_reg8 #(
    .ADDR(MCMR_ADDR_MASK_SECOND),
    .RST(MCMR_RST_MASK_SECOND)
  ) mask_second_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(i_req),
    .o_value(mask_second_q)
  );

  mcmr_reg8 #(
    .ADDR(MCMR_ADDR_TEMP_OFFSET),
    .RST(MCMR_RST_TEMP_OFFSET)
  ) temp_offset_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(i_req),
    .o_value(temp_offset_q)
  );

  always_comb
  begin
    rvalid_d = i_req.rd;
    rdata_d = rdata_q;
    if (i_req.rd)
    begin
      case (i_req.addr)
        MCMR_ADDR_CONV_SETUP: rdata_d = conv_setup_q;
        MCMR_ADDR_MASK_FIRST: rdata_d = mask_first_q;
        MCMR_ADDR_MASK_SECOND: rdata_d = mask_second_q;
        MCMR_ADDR_TEMP_OFFSET: rdata_d = temp_offset_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;

  // ---------------------------------------------------------------
  // Converter control and clock divider
  // ---------------------------------------------------------------
  // Divider keeps counting across a speed change, so the first tick after it may be short
  logic [MCMR_DIV_W-1:0] div_cnt_q;
  logic [MCMR_DIV_W-1:0] div_cnt_d;
  logic [MCMR_DIV_W-1:0] div_limit;
  logic tick_q;
  logic tick_d;
  logic fast_q;
  logic fast_d;
  logic ref_q;
  logic ref_d;
  logic bypass_q;
  logic bypass_d;

  always_comb
  begin
    fast_d = conv_setup_q[MCMR_FAST_CONV_SEL_BIT];
    ref_d = conv_setup_q[MCMR_REFERENCE_SEL_BIT];
    bypass_d = conv_setup_q[MCMR_FAST_CONV_SEL_BIT];
    div_limit = fast_q ? MCMR_DIV_W'(MCMR_FAST_DIV - 1)
                       : MCMR_DIV_W'(MCMR_SLOW_DIV - 1);
    tick_d = 1'b0;
    div_cnt_d = div_cnt_q + 1'b1;
    if (div_cnt_q >= div_limit)
    begin
      div_cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_cnt_q <= '0;
      tick_q <= 1'b0;
      fast_q <= 1'b0;
      ref_q <= 1'b0;
      bypass_q <= 1'b0;
    end
    else
    begin
      div_cnt_q <= div_cnt_d;
      tick_q <= tick_d;
      fast_q <= fast_d;
      ref_q <= ref_d;
      bypass_q <= bypass_d;
    end
  end

  assign o_fast_conv_sel = fast_q;
  assign o_reference_sel = ref_q;
  assign o_diode_filter_bypass = bypass_q;
  assign o_conv_clk_tick = tick_q;

  // ---------------------------------------------------------------
  // Interrupt gating
  // ---------------------------------------------------------------
  logic [12:0] src_flat;
  logic [12:0] mask_flat;
  logic int_pin_q, int_pin_d;
  logic any_irq;

  always_comb
  begin
    src_flat = i_irq_src;
    mask_flat[1:0] = mask_first_q[1:0];
    mask_flat[3:2] = mask_first_q[3:2];
    mask_flat[4] = mask_first_q[4];
    mask_flat[7:5] = mask_first_q[7:5];
    mask_flat[12:8] = mask_second_q[MCMR_MASK_SECOND_USED-1:0];
    any_irq = |(src_flat & ~mask_flat);
    // Disabled pin rests at its inactive level
    if (i_int_pin_disable)
      int_pin_d = ~i_int_pin_active_high;
    else
      int_pin_d = i_int_pin_active_high ? any_irq : ~any_irq;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      int_pin_q <= 1'b1;
    else
      int_pin_q <= int_pin_d;
  end

  assign o_int_pin = int_pin_q;

  // ---------------------------------------------------------------
  // Internal temperature offset
  // ---------------------------------------------------------------
  // Sum saturates rather than wrapping, so a large offset cannot flip sign
  localparam int SUM_W = TEMP_W + 1;
  logic signed [SUM_W-1:0] sum;
  logic signed [SUM_W-1:0] off_ext;
  logic [TEMP_W-1:0] temp_q, temp_d;
  logic tvalid_q, tvalid_d;

  always_comb
  begin
    off_ext = SUM_W'($signed({temp_offset_q, {FRAC_W{1'b0}}}));
    sum = SUM_W'($signed(i_temp_raw)) + off_ext;
    temp_d = temp_q;
    tvalid_d = i_temp_valid;
    if (i_temp_valid)
    begin
      if (sum[SUM_W-1] != sum[SUM_W-2])
        temp_d = sum[SUM_W-1] ? {1'b1, {(TEMP_W-1){1'b0}}} : {1'b0, {(TEMP_W-1){1'b1}}};
      else
        temp_d = sum[TEMP_W-1:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      temp_q <= '0;
      tvalid_q <= 1'b0;
    end
    else
    begin
      temp_q <= temp_d;
      tvalid_q <= tvalid_d;
    end
  end

  assign o_temp_result = temp_q;
  assign o_temp_valid = tvalid_q;

endmodule // mcmr_regs

// ---------------------------------------------------------------
// One host register: own address decode and storage
// ---------------------------------------------------------------
module mcmr_reg8
#(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] RST = 8'h00
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Host write request
  input wire mcmr_pkg::mcmr_reg_req_s i_req,
  // Stored value
  output logic [7:0] o_value
);
  import mcmr_pkg::*;

  logic [7:0] value_q;
  logic [7:0] value_d;

  always_comb
  begin
    value_d = value_q;
    if (i_req.wr && i_req.addr == ADDR)
      value_d = i_req.wdata;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      value_q <= RST;
    else
      value_q <= value_d;
  end

  assign o_value = value_q;

endmodule // mcmr_reg8

// ---- tb/mcmr_host.sv ----
`timescale 1ns/1ps
module mcmr_host (
  // Bus side
  input wire logic i_clk,
  output mcmr_pkg::mcmr_reg_req_s o_req
);
  import mcmr_pkg::*;
  initial o_req = '0;
  // Reserved bits are forced legal, so no scenario can break the host's duty
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (w && a == MCMR_ADDR_CONV_SETUP) v = (d & 8'h11) | 8'h08;
    if (w && a == MCMR_ADDR_MASK_SECOND) v = d & 8'h1f;
    @(negedge i_clk);
    o_req = '{wr: w, rd: !w, addr: a, wdata: v};
    @(negedge i_clk);
    o_req = '0;
  endtask
endmodule // mcmr_host

// ---- tb/mcmr_regs_chk.sv ----
`timescale 1ns/1ps
module mcmr_regs_chk
#(
  parameter int TEMP_W = 10,
  parameter int FRAC_W = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire mcmr_pkg::mcmr_reg_req_s i_req,
  input wire mcmr_pkg::mcmr_irq_src_s i_irq_src,
  input wire logic i_int_pin_disable,
  input wire logic i_int_pin_active_high,
  input wire logic o_int_pin,
  input wire logic o_fast_conv_sel,
  input wire logic o_reference_sel,
  input wire logic o_diode_filter_bypass,
  input wire logic o_conv_clk_tick,
  input wire logic i_temp_valid,
  input wire logic o_temp_valid
);
  import mcmr_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [16:0] gap_q;
  logic [16:0] gap_d;
  logic [12:0] mask_q;
  logic [12:0] mask_d;
  logic mix_q;
  logic mix_d;
  logic sel_q;
  // An interval with a speed change is not judged
  always_comb
  begin
    gap_d = o_conv_clk_tick ? 17'h0 : gap_q + 17'h1;
    mix_d = (o_conv_clk_tick ? 1'b0 : mix_q) | (o_fast_conv_sel ^ sel_q);
    mask_d = mask_q;
    if (i_req.wr && i_req.addr == MCMR_ADDR_MASK_FIRST) mask_d[7:0] = i_req.wdata;
    if (i_req.wr && i_req.addr == MCMR_ADDR_MASK_SECOND) mask_d[12:8] = i_req.wdata[4:0];
  end
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      {gap_q, mask_q, mix_q, sel_q} <= {30'h0, 1'b1, 1'b0};
    else
      {gap_q, mask_q, mix_q, sel_q} <= {gap_d, mask_d, mix_d, o_fast_conv_sel};
  sequence setup_wr;
    i_req.wr && i_req.addr == MCMR_ADDR_CONV_SETUP;
  endsequence
  fast_follow_a: assert property (
    setup_wr |-> ##2 o_fast_conv_sel == $past(i_req.wdata[0], 2)) else $error("fast select");
  ref_follow_a: assert property (
    setup_wr |-> ##2 o_reference_sel == $past(i_req.wdata[4], 2)) else $error("reference select");
  bypass_tie_a: assert property (
    o_diode_filter_bypass == o_fast_conv_sel) else $error("filter bypass");
  tick_period_a: assert property (
    o_conv_clk_tick && !mix_q |-> gap_q == (o_fast_conv_sel ? MCMR_FAST_DIV : MCMR_SLOW_DIV) - 1)
    else $error("tick period");
  pin_idle_a: assert property (
    (i_int_pin_disable || (i_irq_src & ~mask_q) == '0) |=> o_int_pin == !$past(i_int_pin_active_high))
    else $error("pin not idle");
  pin_active_a: assert property (
    (!i_int_pin_disable && (i_irq_src & ~mask_q) != '0) |=> o_int_pin == $past(i_int_pin_active_high))
    else $error("pin not active");
  temp_valid_a: assert property (
    1 |=> o_temp_valid == $past(i_temp_valid)) else $error("temp valid");
  rst_value_a: assert property (
    $fell(i_rst) |-> !o_fast_conv_sel && !o_reference_sel) else $error("reset setup");
endmodule // mcmr_regs_chk

// ---- tb/mcmr_regs_tb.sv ----
`timescale 1ns/1ps
module mcmr_regs_tb;
  import mcmr_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic [2:0] cexp;
  } mcmr_row_s;
  logic i_clk, i_rst, i_int_pin_disable, i_int_pin_active_high, i_temp_valid, o_rvalid;
  logic o_int_pin, o_fast_conv_sel, o_reference_sel, o_diode_filter_bypass;
  logic o_conv_clk_tick, o_temp_valid;
  logic [7:0] o_rdata;
  logic [9:0] i_temp_raw, o_temp_result;
  logic [12:0] src;
  logic [2:0] cfg;
  mcmr_reg_req_s i_req;
  mcmr_irq_src_s i_irq_src;
  int errors, comparisons, n;
  logic [7:0] raddr [4] = '{8'h1a, 8'h1d, 8'h1e, 8'h1f};
  logic [7:0] rrst [4] = '{8'h08, 8'h00, 8'h00, 8'h00};
  // Columns: address, written, read back, {reference, fast, bypass}
  mcmr_row_s rows [6] = '{'{8'h1a, 8'h09, 8'h09, 3'h3}, '{8'h1a, 8'h18, 8'h18, 3'h4},
    '{8'h1d, 8'ha5, 8'ha5, 3'h4}, '{8'h1e, 8'hff, 8'h1f, 3'h4},
    '{8'h1f, 8'hfe, 8'hfe, 3'h4}, '{8'h30, 8'h55, 8'h00, 3'h4}};
  assign cfg = {o_reference_sel, o_fast_conv_sel, o_diode_filter_bypass};
  mcmr_regs mcmr_regs_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(i_req),
    .o_rdata(o_rdata),
    .o_rvalid(o_rvalid),
    .i_irq_src(i_irq_src),
    .i_int_pin_disable(i_int_pin_disable),
    .i_int_pin_active_high(i_int_pin_active_high),
    .o_int_pin(o_int_pin),
    .o_fast_conv_sel(o_fast_conv_sel),
    .o_reference_sel(o_reference_sel),
    .o_diode_filter_bypass(o_diode_filter_bypass),
    .o_conv_clk_tick(o_conv_clk_tick),
    .i_temp_valid(i_temp_valid),
    .i_temp_raw(i_temp_raw),
    .o_temp_valid(o_temp_valid),
    .o_temp_result(o_temp_result)
  );
  mcmr_host mcmr_host_inst (.i_clk(i_clk), .o_req(i_req));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rst_chk();
    foreach (raddr[k])
    begin
      mcmr_host_inst.put(1'b0, raddr[k], 8'h00);
      chk("reset value", 16'({o_rvalid, o_rdata}), 16'({1'b1, rrst[k]}));
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    #300000;
    errors++;
    wrap_up();
  end
  initial
  begin
    // Pin starts enabled and active high, no temperature result pending
    {i_rst, i_int_pin_disable, i_int_pin_active_high, i_temp_valid} = 4'ha;
    {i_irq_src, i_temp_raw} = '0;
    repeat (4) @(negedge i_clk);
    i_rst = 0;
    rst_chk();
    foreach (rows[k])
    begin
      mcmr_host_inst.put(1'b1, rows[k].addr, rows[k].wdata);
      mcmr_host_inst.put(1'b0, rows[k].addr, 8'h00);
      chk("readback", 16'({o_rvalid, o_rdata}), 16'({1'b1, rows[k].rexp}));
      chk("setup", 16'(cfg), 16'(rows[k].cexp));
    end
    // Offset is -2 C, so 10 C in quarter steps lands on 8 C
    {i_temp_raw, i_temp_valid} = {10'd40, 1'b1};
    @(negedge i_clk);
    i_temp_valid = 0;
    chk("temp", 16'({o_temp_valid, o_temp_result}), 16'({1'b1, 10'd32}));
    // Offset pushes the coldest reading below range, so it must stop at the floor
    {i_temp_raw, i_temp_valid} = {10'h200, 1'b1};
    @(negedge i_clk);
    i_temp_valid = 0;
    chk("temp floor", 16'({o_temp_valid, o_temp_result}), 16'({1'b1, 10'h200}));
    for (int i = 0; i < 13; i++)
    begin
      src = 13'h1 << i;
      i_irq_src = src;
      mcmr_host_inst.put(1'b1, 8'h1d, src[7:0]);
      mcmr_host_inst.put(1'b1, 8'h1e, {3'h0, src[12:8]});
      @(negedge i_clk);
      chk("masked", 16'(o_int_pin), 16'h0000);
      mcmr_host_inst.put(1'b1, 8'h1d, ~src[7:0]);
      mcmr_host_inst.put(1'b1, 8'h1e, {3'h0, ~src[12:8]});
      @(negedge i_clk);
      chk("unmasked", 16'(o_int_pin), 16'h0001);
    end
    i_int_pin_active_high = 0;
    repeat (2) @(negedge i_clk);
    chk("active low", 16'(o_int_pin), 16'h0000);
    i_int_pin_disable = 1;
    repeat (2) @(negedge i_clk);
    chk("disabled", 16'(o_int_pin), 16'h0001);
    mcmr_host_inst.put(1'b1, 8'h1a, 8'h09);
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(negedge i_clk);
        n++;
      end while (!o_conv_clk_tick && n < 9000);
    end
    chk("tick gap", 16'(n), 16'(MCMR_FAST_DIV));
    i_rst = 1;
    @(negedge i_clk);
    i_rst = 0;
    rst_chk();
    wrap_up();
  end
endmodule // mcmr_regs_tb
bind mcmr_regs mcmr_regs_chk #(.TEMP_W(TEMP_W), .FRAC_W(FRAC_W)) mcmr_regs_chk_inst (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_req(i_req),
  .i_irq_src(i_irq_src),
  .i_int_pin_disable(i_int_pin_disable),
  .i_int_pin_active_high(i_int_pin_active_high),
  .o_int_pin(o_int_pin),
  .o_fast_conv_sel(o_fast_conv_sel),
  .o_reference_sel(o_reference_sel),
  .o_diode_filter_bypass(o_diode_filter_bypass),
  .o_conv_clk_tick(o_conv_clk_tick),
  .i_temp_valid(i_temp_valid),
  .o_temp_valid(o_temp_valid)
);
